/* File: hw/static_link_regs.vh */
`ifndef STATIC_LINK_REGS_VH
`define STATIC_LINK_REGS_VH

// register index of the first and last static link configuration word
`define SLC_FIRST_IDX 10'h0A0
`define SLC_LAST_IDX 10'h0A7
// byte address = index * 4, so the index sits above two low address bits
`define SLC_IDX_LSB 2
// field positions
`define SLC_EN_BIT 31
`define SLC_PROC_BIT 8
`define SLC_CHAN_MSB 4
`define SLC_CHAN_LSB 0
// byte lanes that hold each field
`define SLC_EN_LANE 3
`define SLC_PROC_LANE 1
`define SLC_CHAN_LANE 0
// reset values
`define SLC_EN_RST 1'h0
`define SLC_PROC_RST 1'h0
`define SLC_CHAN_RST 5'h00
// xor that maps register slot to link number (slot order C,D,A,B,G,H,E,F)
`define SLC_SLOT_SWAP 3'h2
// field and table sizes
`define SLC_CHAN_W 5
`define SLC_NSLOT 8
`define SLC_SLOT_W 3
// value of an unmapped or idle read
`define SLC_WORD_RST 32'h00000000

`endif

/* File: hw/static_link_forwarding.v */
// Function
// - static enable set: link traffic goes to configured channel end, no routing
// - eight config words, lowest to highest, serve links C,D,A,B,G,H,E,F
// - one read-write bit picks the destination processor, resets to zero
// - five-bit read-write field picks destination channel end, resets to zero
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "static_link_regs.vh"

module static_link_forwarding #(
  parameter NLINK = 8,
  parameter DW = 8,
  parameter AW = 12
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // incoming tokens per link, index 0..7 = links A..H
  input wire [NLINK-1:0] lnk_vld,
  input wire [NLINK*DW-1:0] lnk_data,
  input wire [NLINK-1:0] lnk_eop,
  // routed path towards the switch
  output reg [NLINK-1:0] rt_vld,
  output reg [NLINK*DW-1:0] rt_data,
  output reg [NLINK-1:0] rt_eop,
  // static path towards the local channel ends
  output reg [NLINK-1:0] st_vld,
  output reg [NLINK*DW-1:0] st_data,
  output reg [NLINK-1:0] st_eop,
  output reg [NLINK-1:0] st_proc,
  output reg [NLINK*5-1:0] st_chan
);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // register slot serving a given link
  function [`SLC_SLOT_W-1:0] slot_of;
    input [`SLC_SLOT_W-1:0] link;
    begin
      slot_of = link ^ `SLC_SLOT_SWAP;
    end
  endfunction

  // channel end field of one slot out of the packed slot vector
  function [`SLC_CHAN_W-1:0] chan_pick;
    input [`SLC_NSLOT*`SLC_CHAN_W-1:0] vec;
    input [`SLC_SLOT_W-1:0] k;
    begin
      chan_pick = vec[k*`SLC_CHAN_W +: `SLC_CHAN_W];
    end
  endfunction

  // read-back word built from the stored fields only
  function [31:0] read_word;
    input en;
    input proc;
    input [`SLC_CHAN_W-1:0] chan;
    begin
      read_word = `SLC_WORD_RST; // reserved positions stay zero
      read_word[`SLC_EN_BIT] = en;
      read_word[`SLC_PROC_BIT] = proc;
      read_word[`SLC_CHAN_MSB:`SLC_CHAN_LSB] = chan;
    end
  endfunction

  // ---------------------------------------------
  // configuration registers, indexed by slot
  // ---------------------------------------------
  reg [`SLC_NSLOT-1:0] en_r;
  reg [`SLC_NSLOT-1:0] proc_r;
  reg [`SLC_NSLOT*`SLC_CHAN_W-1:0] chan_r;

  // word index of the bus address; the two low bits pick a byte
  wire [AW-`SLC_IDX_LSB-1:0] idx = wb_adr_i[AW-1:`SLC_IDX_LSB];
  // a request counts once: a strobe still held during ack is not new
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  reg hit;
  reg [`SLC_SLOT_W-1:0] slot;

  // address decode; outside the table the bus is answered but nothing stored
  always @* begin
    hit = 1'b0;
    slot = idx[`SLC_SLOT_W-1:0]; // first index is a multiple of eight
    if (idx < `SLC_FIRST_IDX) begin
      hit = 1'b0;
    end else if (idx > `SLC_LAST_IDX) begin
      hit = 1'b0;
    end else begin
      hit = 1'b1;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `SLC_WORD_RST;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i && hit) begin
        wb_dat_o <= read_word(en_r[slot], proc_r[slot], chan_pick(chan_r, slot));
      end else begin
        // unmapped reads and idle cycles show zero
        wb_dat_o <= `SLC_WORD_RST;
      end
    end
  end

  // writes land on the request edge; reserved bits are simply not stored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= {`SLC_NSLOT{`SLC_EN_RST}};
      proc_r <= {`SLC_NSLOT{`SLC_PROC_RST}};
      chan_r <= {`SLC_NSLOT{`SLC_CHAN_RST}};
    end else if (req && wb_we_i && hit) begin
      if (wb_sel_i[`SLC_EN_LANE]) begin
        en_r[slot] <= wb_dat_i[`SLC_EN_BIT];
      end
      if (wb_sel_i[`SLC_PROC_LANE]) begin
        proc_r[slot] <= wb_dat_i[`SLC_PROC_BIT];
      end
      if (wb_sel_i[`SLC_CHAN_LANE]) begin
        chan_r[slot*`SLC_CHAN_W +: `SLC_CHAN_W] <= wb_dat_i[`SLC_CHAN_MSB:`SLC_CHAN_LSB];
      end
    end
  end

  // ---------------------------------------------
  // per-link steering
  // ---------------------------------------------
  // mode and destination are latched at the first token of a packet so
  // that a config write mid-packet never splits one packet over two paths
  reg [NLINK-1:0] inpkt_r;
  reg [NLINK-1:0] mode_r;
  reg [NLINK-1:0] dproc_r;
  reg [NLINK*`SLC_CHAN_W-1:0] dchan_r;
  // path and destination that apply to the token now on each link
  reg [NLINK-1:0] use_st;
  reg [NLINK-1:0] proc_now;
  reg [NLINK*`SLC_CHAN_W-1:0] chan_now;
  reg [`SLC_SLOT_W-1:0] s;
  integer i;
  integer j;

  // ---------------------------------------------
  // path selection
  // ---------------------------------------------
  // a packet in flight keeps what it latched; an idle link follows the
  // live config, so st_proc and st_chan show where a new packet would go
  always @* begin
    use_st = {NLINK{1'b0}};
    proc_now = {NLINK{1'b0}};
    chan_now = {NLINK*`SLC_CHAN_W{1'b0}};
    s = {`SLC_SLOT_W{1'b0}};
    for (j = 0; j < NLINK; j = j + 1) begin
      s = slot_of(j[`SLC_SLOT_W-1:0]);
      if (inpkt_r[j]) begin
        use_st[j] = mode_r[j];
        proc_now[j] = dproc_r[j];
        chan_now[j*`SLC_CHAN_W +: `SLC_CHAN_W] = dchan_r[j*`SLC_CHAN_W +: `SLC_CHAN_W];
      end else begin
        use_st[j] = en_r[s];
        proc_now[j] = proc_r[s];
        chan_now[j*`SLC_CHAN_W +: `SLC_CHAN_W] = chan_pick(chan_r, s);
      end
    end
  end

  // ---------------------------------------------
  // packet tracking
  // ---------------------------------------------
  // the first token of a packet freezes path and destination until eop
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inpkt_r <= {NLINK{1'b0}};
      mode_r <= {NLINK{1'b0}};
      dproc_r <= {NLINK{1'b0}};
      dchan_r <= {NLINK*`SLC_CHAN_W{1'b0}};
    end else begin
      for (i = 0; i < NLINK; i = i + 1) begin
        if (lnk_vld[i] && !inpkt_r[i]) begin
          mode_r[i] <= use_st[i];
          dproc_r[i] <= proc_now[i];
          dchan_r[i*`SLC_CHAN_W +: `SLC_CHAN_W] <= chan_now[i*`SLC_CHAN_W +: `SLC_CHAN_W];
        end
        if (lnk_vld[i]) begin
          inpkt_r[i] <= !lnk_eop[i]; // the eop token closes the packet
        end
      end
    end
  end

  // ---------------------------------------------
  // output registers
  // ---------------------------------------------
  // static path: skips the switch, tagged with processor and channel end;
  // data goes to both paths unqualified, which saves a mux per data bit
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_vld <= {NLINK{1'b0}};
      st_data <= {NLINK*DW{1'b0}};
      st_eop <= {NLINK{1'b0}};
      st_proc <= {NLINK{1'b0}};
      st_chan <= {NLINK*`SLC_CHAN_W{1'b0}};
    end else begin
      st_vld <= lnk_vld & use_st;
      st_eop <= lnk_vld & use_st & lnk_eop;
      st_data <= lnk_data;
      st_proc <= proc_now;
      st_chan <= chan_now;
    end
  end

  // routed path: an enable left clear hands the token to the switch
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rt_vld <= {NLINK{1'b0}};
      rt_data <= {NLINK*DW{1'b0}};
      rt_eop <= {NLINK{1'b0}};
    end else begin
      rt_vld <= lnk_vld & ~use_st;
      rt_eop <= lnk_vld & ~use_st & lnk_eop;
      rt_data <= lnk_data;
    end
  end

endmodule // static_link_forwarding

/* File: verif/slf_checker.sv */
`timescale 1ns/1ps
module slf_checker #(parameter NLINK = 8, parameter DW = 8) (
  // clock, reset, bus answer
  input wire clk,
  input wire arst_n,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  // link paths
  input wire [NLINK-1:0] lnk_vld,
  input wire [NLINK*DW-1:0] lnk_data,
  input wire [NLINK-1:0] rt_vld,
  input wire [NLINK-1:0] st_vld,
  input wire [NLINK*DW-1:0] st_data,
  input wire [NLINK-1:0] st_proc,
  input wire [NLINK*5-1:0] st_chan
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_one_path: assert property (|lnk_vld |=> (rt_vld | st_vld) == $past(lnk_vld))
    else $error("token lost or duplicated");
  a_no_double: assert property ((rt_vld & st_vld) == 0)
    else $error("token on both paths");
  a_static_data: assert property (st_vld[0] |-> st_data[DW-1:0] == $past(lnk_data[DW-1:0]))
    else $error("static data altered");
  a_rsvd_zero: assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & 32'h7FFFFEE0) == 0)
    else $error("reserved bits set");
  a_cfg_reset: assert property ($rose(arst_n) |-> st_proc == 0 && st_chan == 0)
    else $error("config not cleared");
  // main traffic kinds
  cover property (|st_vld);
  cover property (|rt_vld);
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i && wb_dat_o[31]);
endmodule // slf_checker
bind static_link_forwarding slf_checker #(.NLINK(NLINK), .DW(DW)) u_chk (.clk(clk),
  .arst_n(arst_n), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .lnk_vld(lnk_vld), .lnk_data(lnk_data), .rt_vld(rt_vld), .st_vld(st_vld),
  .st_data(st_data), .st_proc(st_proc), .st_chan(st_chan));

/* File: verif/link_source.sv */
`timescale 1ns/1ps
module link_source (
  // token lines towards the block
  input wire clk,
  output logic [7:0] vld,
  output logic [63:0] data,
  output logic [7:0] eop
);
  initial begin
    vld = 8'h00;
    data = 64'h0;
    eop = 8'h00;
  end
  // idle data is inverted so stale data never matches the token just sent; vld and eop are cleared
  task send(input int l, input [7:0] d, input bit last = 1'b1);
    @(posedge clk);
    vld <= 8'h01 << l;
    eop <= last ? 8'h01 << l : 8'h00;
    data[l*8+:8] <= d;
    @(posedge clk);
    {vld, eop, data} <= {16'h0, ~data};
  endtask
endmodule // link_source

/* File: verif/static_link_forwarding_bench.sv */
`timescale 1ns/1ps
module static_link_forwarding_bench;
  logic clk, arst_n, cyc, stb, we;
  logic [3:0] sel;
  logic [11:0] adr;
  logic [31:0] wdat, q;
  wire [31:0] rdat;
  wire ack;
  wire [7:0] lv, le, rv, re, sv, se, sp;
  wire [63:0] ld, rd, sd;
  wire [39:0] sc;
  int error_cnt = 0;
  int comparisons = 0;
  static_link_forwarding dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .lnk_vld(lv), .lnk_data(ld), .lnk_eop(le), .rt_vld(rv), .rt_data(rd),
    .rt_eop(re), .st_vld(sv), .st_data(sd), .st_eop(se), .st_proc(sp), .st_chan(sc));
  link_source src (.clk(clk), .vld(lv), .data(ld), .eop(le));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
  task ck(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("FAIL %0t mismatch", $time);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // classic cycle: held until ack is sampled, then one idle cycle
  task bus(input logic w, input [3:0] s, input [11:0] a, input [31:0] d);
    @(posedge clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, s, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // reset values, last pass hits the unmapped word after the block
  task t_reset;
    for (int i = 0; i < 9; i++) begin
      bus(0, 4'hF, 12'h280 + 12'(4 * i), 0);
      ck(q === 32'h0);
    end
  endtask
  // link served by each slot in address order: C,D,A,B,G,H,E,F (A = 0)
  function automatic int link_of(input int slot);
    int map [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    return map[slot];
  endfunction
  // each slot in address order gets its own channel end
  task t_static;
    for (int i = 0; i < 8; i++) begin
      bus(1, 4'hF, 12'h280 + 12'(4 * i), 32'hFFFFFFFF - i);
      bus(0, 4'hF, 12'h280 + 12'(4 * i), 0);
      ck(q === 32'h8000011F - i);
      src.send(link_of(i), 8'hA5 ^ 8'(i));
      #1;
      ck(sv === 8'h01 << link_of(i) && se === sv && rv === 8'h00);
      ck(sp[link_of(i)] === 1'b1 && sc[5 * link_of(i)+:5] === 5'(31 - i));
      ck(sd[8 * link_of(i)+:8] === (8'hA5 ^ 8'(i)));
    end
  endtask
  // clearing only the enable lane sends link C back to routing
  task t_routed;
    bus(1, 4'h8, 12'h280, 0);
    bus(0, 4'hF, 12'h280, 0);
    ck(q === 32'h0000011F);
    src.send(2, 8'h3C);
    #1;
    ck(rv === 8'h04 && re === 8'h04 && sv === 8'h00 && rd[23:16] === 8'h3C);
  endtask
  // a packet keeps its path when static mode is switched on mid-packet
  task t_midpkt;
    src.send(2, 8'h11, 0);
    #1;
    ck(rv === 8'h04 && re === 8'h00 && sv === 8'h00);
    bus(1, 4'hA, 12'h280, 32'h80000000);
    bus(0, 4'hF, 12'h280, 0);
    ck(q === 32'h8000001F);
    src.send(2, 8'h22);
    #1;
    ck(rv === 8'h04 && re === 8'h04 && rd[23:16] === 8'h22 && sp[2] === 1'b1);
    src.send(2, 8'h33);
    #1;
    ck(sv === 8'h04 && se === 8'h04 && rv === 8'h00 && sd[23:16] === 8'h33);
    ck(sp[2] === 1'b0 && sc[14:10] === 5'h1F);
  endtask
  initial begin
    {cyc, stb, we, sel, adr, wdat} = 0;
    arst_n = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1;
    t_reset;
    t_static;
    t_routed;
    t_midpkt;
    final_report;
  end
endmodule // static_link_forwarding_bench
